/* hdl/scos_consts.vh */
// constants of the six-channel output select block
`ifndef SCOS_CONSTS_VH
`define SCOS_CONSTS_VH
`define SCOS_REG_RST        8'hff
`define SCOS_CH_LSB         2
`define SCOS_CH_MSB         7
`define SCOS_UNUSED_BITS    2'h3
`define SCOS_OP_WR_SRC      6'h2a
`define SCOS_OP_RD_SRC      6'h29
`define SCOS_OP_WR_SW       6'h26
`define SCOS_OP_RD_SW       6'h25
`define SCOS_OP_RD_DIAG     6'h20
`define SCOS_ADDR_CODE      2'h2
`define SCOS_FRAME_BITS     5'h10
`define SCOS_CNT_ADDR       5'h01
`define SCOS_CNT_INSTR      5'h07
`define SCOS_CNT_SO_ON      5'h02
`define SCOS_DIAG_IDLE      16'h3fff
`endif

/* hdl/scos_output_select.v */
// six-channel output select: spi register bank and per-channel output decision
//
// Behaviour
// - reset pin low forces all six power outputs off.
// - serial control: output on when switch bit is 0, off when 1.
// - parallel control, polarity 0: low input turns output on.
// - parallel control, polarity 1: high input turns output on.
// - serial switch bits are active low.
// - polarity pin sets input sense for all six channels together.
// - source-select bits 7..2 map to channels 6..1.
// - serial-command bits 7..2 map to channels 6..1.
// - bits 1..0 of both registers ignore writes and read as one.
// - source-select write uses its instruction byte then six select bits.
// - serial-command write uses its instruction byte then six switch bits.
// - read-back second byte holds channel bits 6..1 then two ones.
// - writes commit only after exactly 16 clock pulses within chip select.
`timescale 1ns/10ps
`include "scos_consts.vh"
module scos_output_select #(
  parameter NCH = 6
) (
  input  wire           i_ref_clk,
  input  wire           i_sys_rst,
  input  wire           i_clk_en,
  input  wire           i_reset_n,
  input  wire           i_input_polarity_pin,
  input  wire [NCH-1:0] i_parallel_input_pin,
  input  wire           i_spi_cs_n,
  input  wire           i_spi_sclk,
  input  wire           i_spi_si,
  input  wire [15:0]    i_diag_word,
  output reg  [NCH-1:0] o_power_output,
  output reg            o_spi_so,
  output reg            o_spi_so_oe,
  output wire [7:0]     o_channel_source_select,
  output wire [7:0]     o_serial_switch_command
);

  // three-stage pin synchronisers; a change counts when stages two and three agree
  reg [2:0] rst_s_q, pol_s_q, cs_s_q, sck_s_q, si_s_q;
  reg [NCH-1:0] in_s1_q, in_s2_q, in_s3_q;
  reg rst_f_q, pol_f_q, cs_f_q, sck_f_q, si_f_q;
  reg [NCH-1:0] in_f_q;

  reg [NCH-1:0] src_q;
  reg [NCH-1:0] sw_q;
  reg [15:0]    shift_q;
  reg [4:0]     cnt_q;
  reg           over_q;
  reg [15:0]    tx_q;
  reg           addr_q;
  integer       k;
  integer       m;

  function agree;
    input [2:0] s;
    input       held;
    begin
      agree = (s[1] == s[2]) ? s[1] : held;
    end
  endfunction

  // register image: channel bits high, unused low bits read as one
  function [7:0] reg_image;
    input [NCH-1:0] ch;
    begin
      reg_image = {ch, `SCOS_UNUSED_BITS};
    end
  endfunction

  // bits 7..2 of an instruction byte name the command; bits 1..0 are don't-care
  function is_op;
    input [7:0] ins;
    input [5:0] code;
    begin
      is_op = (ins[7:2] == code);
    end
  endfunction

  // one power stage from its own input, select and switch bits plus the shared pins
  function chan_on;
    input       rst_ok;
    input       par_sel;
    input       sw_bit;
    input       in_bit;
    input       pol;
    begin
      if (!rst_ok) begin
        chan_on = 1'b0;
      end else if (!par_sel) begin
        chan_on = ~sw_bit;
      end else begin
        chan_on = ~(in_bit ^ pol);
      end
    end
  endfunction

  assign o_channel_source_select = reg_image(src_q);
  assign o_serial_switch_command = reg_image(sw_q);

  wire sck_fall = sck_f_q & ~agree(sck_s_q, sck_f_q);
  wire sck_rise = ~sck_f_q & agree(sck_s_q, sck_f_q);
  wire cs_fall  = cs_f_q & ~agree(cs_s_q, cs_f_q);
  wire cs_rise  = ~cs_f_q & agree(cs_s_q, cs_f_q);
  wire [15:0] shift_d = {shift_q[14:0], si_f_q};
  // a write commits only on an addressed frame of exactly sixteen falling edges
  wire        frame_ok = !over_q && cnt_q == `SCOS_FRAME_BITS && shift_q[15:14] == `SCOS_ADDR_CODE;
  // so stays released over the two address bits and for frames meant for another device
  wire        so_drive = addr_q && cnt_q >= `SCOS_CNT_SO_ON;

  always @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      rst_s_q <= 3'h0;
      pol_s_q <= 3'h0;
      cs_s_q  <= 3'h7;
      sck_s_q <= 3'h0;
      si_s_q  <= 3'h0;
      in_s1_q <= {NCH{1'b0}};
      in_s2_q <= {NCH{1'b0}};
      in_s3_q <= {NCH{1'b0}};
      rst_f_q <= 1'b0;
      pol_f_q <= 1'b0;
      cs_f_q  <= 1'b1;
      sck_f_q <= 1'b0;
      si_f_q  <= 1'b0;
      in_f_q  <= {NCH{1'b0}};
    end else if (i_clk_en) begin
      rst_s_q <= {rst_s_q[1:0], i_reset_n};
      pol_s_q <= {pol_s_q[1:0], i_input_polarity_pin};
      cs_s_q  <= {cs_s_q[1:0], i_spi_cs_n};
      sck_s_q <= {sck_s_q[1:0], i_spi_sclk};
      si_s_q  <= {si_s_q[1:0], i_spi_si};
      in_s1_q <= i_parallel_input_pin;
      in_s2_q <= in_s1_q;
      in_s3_q <= in_s2_q;
      rst_f_q <= agree(rst_s_q, rst_f_q);
      pol_f_q <= agree(pol_s_q, pol_f_q);
      cs_f_q  <= agree(cs_s_q, cs_f_q);
      sck_f_q <= agree(sck_s_q, sck_f_q);
      si_f_q  <= agree(si_s_q, si_f_q);
      for (k = 0; k < NCH; k = k + 1) begin
        if (in_s2_q[k] == in_s3_q[k]) begin
          in_f_q[k] <= in_s2_q[k];
        end
      end
    end
  end

  // spi frame: sample on falling sclk, shift out on rising sclk, commit on cs rise
  always @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      src_q       <= {NCH{1'b1}};
      sw_q        <= {NCH{1'b1}};
      shift_q     <= 16'h0000;
      cnt_q       <= 5'h00;
      over_q      <= 1'b0;
      tx_q        <= `SCOS_DIAG_IDLE;
      addr_q      <= 1'b0;
      o_spi_so    <= 1'b1;
      o_spi_so_oe <= 1'b0;
    end else if (i_clk_en) begin
      if (!rst_f_q) begin
        src_q       <= {NCH{1'b1}};
        sw_q        <= {NCH{1'b1}};
        shift_q     <= 16'h0000;
        cnt_q       <= 5'h00;
        over_q      <= 1'b0;
        addr_q      <= 1'b0;
        o_spi_so_oe <= 1'b0;
      end else if (cs_fall) begin
        cnt_q       <= 5'h00;
        over_q      <= 1'b0;
        addr_q      <= 1'b0;
        tx_q        <= i_diag_word;
        o_spi_so    <= i_diag_word[15];
        o_spi_so_oe <= 1'b0;
      end else if (cs_rise) begin
        o_spi_so_oe <= 1'b0;
        if (frame_ok) begin
          if (is_op(shift_q[15:8], `SCOS_OP_WR_SRC)) begin
            src_q <= shift_q[7:8-NCH];
          end
          if (is_op(shift_q[15:8], `SCOS_OP_WR_SW)) begin
            sw_q <= shift_q[7:8-NCH];
          end
        end
      end else if (!cs_f_q) begin
        if (sck_fall) begin
          shift_q <= shift_d;
          if (cnt_q == `SCOS_FRAME_BITS) begin
            over_q <= 1'b1;
          end else begin
            cnt_q <= cnt_q + 5'h01;
          end
          if (cnt_q == `SCOS_CNT_ADDR) begin
            addr_q <= (shift_d[1:0] == `SCOS_ADDR_CODE);
          end
          // the command is known on the eighth falling edge, just before the second byte is launched
          if (cnt_q == `SCOS_CNT_INSTR && addr_q) begin
            if (is_op(shift_d[7:0], `SCOS_OP_RD_SRC)) begin
              tx_q[15:8] <= reg_image(src_q);
            end else if (is_op(shift_d[7:0], `SCOS_OP_RD_SW)) begin
              tx_q[15:8] <= reg_image(sw_q);
            end
          end
        end
        // rising edge k launches frame bit k, so the host takes it on the falling edge that follows
        if (sck_rise) begin
          tx_q        <= {tx_q[14:0], 1'b1};
          o_spi_so    <= tx_q[15];
          o_spi_so_oe <= so_drive;
        end
      end
    end
  end

  // per-channel output decision
  always @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_power_output <= {NCH{1'b0}};
    end else if (i_clk_en) begin
      for (m = 0; m < NCH; m = m + 1) begin
        o_power_output[m] <= chan_on(rst_f_q, src_q[m], sw_q[m], in_f_q[m], pol_f_q);
      end
    end
  end

endmodule

/* dv/scos_chk_sva.sv */
// concurrent checks on the output select ports
`timescale 1ns/10ps
module scos_chk #(parameter NCH = 6) (
  input wire           i_ref_clk,
  input wire           i_sys_rst,
  input wire           i_reset_n,
  input wire           i_input_polarity_pin,
  input wire [NCH-1:0] i_parallel_input_pin,
  input wire           i_spi_cs_n,
  input wire           o_spi_so_oe,
  input wire [NCH-1:0] o_power_output,
  input wire [7:0]     o_channel_source_select,
  input wire [7:0]     o_serial_switch_command
);
  wire [5:0] s = o_channel_source_select[7:2];
  wire [5:0] w = o_serial_switch_command[7:2];
  wire [5:0] p = i_parallel_input_pin;
  wire [5:0] o = o_power_output;
  wire       g = i_input_polarity_pin;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  // pins and registers settled long enough to pass the synchronisers
  sequence q(c);
    (i_reset_n && c && $stable({g, p, s, w}))[*8];
  endsequence
  chk_off_in_reset: assert property (!i_reset_n [*7] |-> o == 0 && w == 6'h3f) else $error("out on");
  chk_src_reset_ff: assert property (!i_reset_n [*7] |-> o_channel_source_select == 8'hff) else $error("src");
  chk_unused_bits_one: assert property (o_channel_source_select[1:0] == 2'h3 && w != 6'h3f
    |-> o_serial_switch_command[1:0] == 2'h3) else $error("low bits");
  chk_serial_low_on: assert property (q(s == 0) |-> o == ~w) else $error("serial");
  chk_par_low_act: assert property (q(&s && !g) |-> o == ~p) else $error("par low");
  chk_par_high_act: assert property (q(&s && g) |-> o == p) else $error("par high");
  chk_channel_mix: assert property (q(1'b1) |-> o == (s & (p ~^ {6{g}}) | ~s & ~w)) else $error("mix");
  chk_regs_hold_idle: assert property ((i_spi_cs_n && i_reset_n) [*8] |=> $stable({s, w})) else $error("reg");
  cover property (!i_spi_cs_n [*8]);
  cover property (o_spi_so_oe);
  cover property (!i_reset_n [*7]);
endmodule

/* dv/scos_host.sv */
// host spi controller model driving frames into the block
`timescale 1ns/10ps
module scos_host (
  input  wire  i_clk,
  input  wire  i_so,
  output logic o_cs_n = 1'b1,
  output logic o_sclk = 1'b0,
  output logic o_si   = 1'b0
);
  task automatic wt(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  // n pulses, msb first; so sampled at the end of each high phase
  task automatic xfer(input logic [15:0] w, input int n, output logic [7:0] rd);
    o_cs_n = 1'b0;
    wt(6);
    for (int i = 0; i < n; i++) begin
      o_si = (i < 16) ? w[15-i] : 1'b0;
      o_sclk = 1'b1;
      wt(6);
      rd = {rd[6:0], i_so};
      o_sclk = 1'b0;
      wt(6);
    end
    o_cs_n = 1'b1;
    o_si = ~o_si;
    wt(12);
  endtask
endmodule

/* dv/six_channel_output_select_tb.sv */
// testbench for the six-channel output select block
`timescale 1ns/10ps
module six_channel_output_select_tb;
  logic       clk = 1'b0, rst = 1'b1, rn = 1'b0, pol = 1'b0, so, oe;
  logic [5:0] par = 6'h3f, out;
  logic [7:0] src, sw, rd;
  wire        cs_n, sclk, si;
  int         errors = 0, check_count = 0;
  always #20 clk = ~clk;
  scos_output_select u_scos_output_select (.i_ref_clk(clk), .i_sys_rst(rst), .i_clk_en(1'b1), .i_reset_n(rn),
    .i_input_polarity_pin(pol), .i_parallel_input_pin(par), .i_spi_cs_n(cs_n), .i_spi_sclk(sclk), .i_spi_si(si),
    .i_diag_word(16'h3fff), .o_power_output(out), .o_spi_so(so), .o_spi_so_oe(oe),
    .o_channel_source_select(src), .o_serial_switch_command(sw));
  scos_host u_host (.i_clk(clk), .i_so(oe ? so : ~so), .o_cs_n(cs_n), .o_sclk(sclk), .o_si(si));
  task automatic chk(input logic [7:0] got, exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] op, input logic [7:0] d, input int n = 16);
    u_host.xfer({op, 2'b00, d}, n, rd);
  endtask
  task automatic t_par;
    chk(src, 8'hff);
    chk({2'b00, out}, 8'h00);
    par = 6'h0c;
    repeat (10) @(negedge clk);
    chk({2'b00, out}, 8'h33);
    pol = 1'b1;
    repeat (10) @(negedge clk);
    chk({2'b00, out}, 8'h0c);
  endtask
  task automatic t_ser;
    wr(6'h2a, 8'h00);
    wr(6'h26, 8'h54);
    chk(src, 8'h03);
    chk({2'b00, out}, 8'h2a);
    wr(6'h25, 8'h00);
    chk(rd, 8'h57);
    wr(6'h29, 8'h00);
    chk(rd, 8'h03);
    wr(6'h26, 8'h00, 15);
    chk(sw, 8'h57);
    wr(6'h26, 8'h00, 17);
    chk(sw, 8'h57);
    wr(6'h0a, 8'hfc);
    chk(src, 8'h03);
    chk(rd, 8'h00);
  endtask
  task automatic t_mix;
    wr(6'h2a, 8'hc0);
    par = 6'h10;
    repeat (10) @(negedge clk);
    chk({2'b00, out}, 8'h1a);
  endtask
  task automatic t_rstn;
    rn = 1'b0;
    repeat (8) @(negedge clk);
    chk({2'b00, out}, 8'h00);
    chk(sw, 8'hff);
    rn = 1'b1;
  endtask
  task automatic results;
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(negedge clk);
    rst = 1'b0;
    rn = 1'b1;
    repeat (10) @(negedge clk);
    t_par;
    t_ser;
    t_mix;
    t_rstn;
    results;
  end
  initial begin
    repeat (5000) @(negedge clk);
    errors++;
    results;
  end
endmodule
bind scos_output_select scos_chk #(.NCH(NCH)) u_chk (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
  .i_reset_n(i_reset_n), .i_input_polarity_pin(i_input_polarity_pin), .i_parallel_input_pin(i_parallel_input_pin),
  .i_spi_cs_n(i_spi_cs_n), .o_spi_so_oe(o_spi_so_oe), .o_power_output(o_power_output),
  .o_channel_source_select(o_channel_source_select), .o_serial_switch_command(o_serial_switch_command));
